//--- logic/pll_bridge_pkg.sv
// Purpose: shared constants and types for the tap-to-pll config bridge
// Assumes: one clock; the tap clock is the system clock clk
// Notes:   config word is shifted lsb first
package pll_bridge_pkg;

    ////////////////////////////////////////////////////////////////////
    // widths
    localparam int CFG_W = 27;
    localparam int IR_W  = 8;

    ////////////////////////////////////////////////////////////////////
    // config word field positions
    localparam int FIX_DLY_BIT = 26;
    localparam int FB_DLY_LSB  = 22;
    localparam int FB_DLY_W    = 4;
    localparam int FB_SEL_LSB  = 20;
    localparam int FB_SEL_W    = 2;
    localparam int OB_MUX_LSB  = 17;
    localparam int OB_MUX_W    = 3;
    localparam int OA_MUX_LSB  = 15;
    localparam int OA_MUX_W    = 2;
    localparam int OA_DIV_LSB  = 13;
    localparam int OA_DIV_W    = 2;
    localparam int OB_DIV_LSB  = 11;
    localparam int OB_DIV_W    = 2;
    localparam int FB_DIV_LSB  = 5;
    localparam int FB_DIV_W    = 6;
    localparam int IN_DIV_LSB  = 0;
    localparam int IN_DIV_W    = 5;

    ////////////////////////////////////////////////////////////////////
    // opcodes and reset values
    localparam logic [7:0] OP_LOAD_CFG = 8'h20;
    localparam logic [7:0] OP_DYNAMIC  = 8'h21;
    localparam logic [7:0] OP_USER_MIN = 8'h10;
    localparam logic [7:0] OP_USER_MAX = 8'h7F;
    localparam logic [7:0] IR_RESET    = 8'hFF;
    localparam logic [7:0] IR_CAPTURE  = 8'h01;
    localparam logic [26:0] STATIC_CFG = 27'h0000000;

    ////////////////////////////////////////////////////////////////////
    // tap controller states
    typedef enum logic [3:0] {
        st_tlr, st_rti,
        st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr,
        st_pa_dr, st_ex2_dr, st_upd_dr,
        st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir,
        st_pa_ir, st_ex2_ir, st_upd_ir
    } tap_state_t;

endpackage : pll_bridge_pkg

//--- logic/pll_cfg_bridge.sv
// Purpose: tap controller plus bridge into a 27-bit pll config register
// Assumes: tms and tdi are synchronous to clk, which is the tap clock
// Notes:   outputs are registered; tdo shows the bit for the next edge

// How it works
// - word bit 26 selects the fixed feedback delay element
// - word bits 25..22 pick the feedback delay line tap
// - bits 19..17 b source, 16..15 a source, 14..13 a div, 12..11 b div
// - word bits 10..5 set the feedback divider
// - word bits 4..0 set the reference input divider
// - the full 8-bit current instruction is presented in parallel
// - load opcode lies within 16..127; other codes are reserved
// - shift, update, capture strobes high only in their dr states
// - tap reset is low from power-up until tms leaves reset state
// - config shift enable is dr shift and load opcode
// - config update is dr update and load opcode
// - config serial input is tdi; config shift clock is the tap clock
// - tdo from ir shift bit in ir shift, else config serial out under load, else holding bit
// - holding bit captures mode or zero; shifts tdi; capture first
// - mode latch cleared in tap reset, loaded on update under dynamic
// - dynamic opcode is 21 hex, load opcode is 20 hex
// - mode high uses latched word, mode low the static word
// - active config changes only on an update or a tap reset, never during shift
// - lock stays high across updates unless the pll is reset
// - config register shifts only while enabled, else holds
module pll_cfg_bridge (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // tap pins
    input  wire logic       tms,
    input  wire logic       tdi,
    output logic            tdo,
    output logic            tdo_oe,
    // user tap interface view
    output logic [7:0]      current_instruction,
    output logic            tap_reset_n,
    output logic            dr_shift_strobe,
    output logic            dr_update_strobe,
    output logic            dr_capture_strobe,
    // pll control
    input  wire logic       pll_lock_in,
    output logic            mode,
    output logic            pll_locked,
    output logic            fixed_delay_select,
    output logic [3:0]      feedback_delay_tap,
    output logic [1:0]      feedback_source_select,
    output logic [2:0]      out_b_source_select,
    output logic [1:0]      out_a_source_select,
    output logic [1:0]      out_a_divider,
    output logic [1:0]      out_b_divider,
    output logic [5:0]      feedback_divider,
    output logic [4:0]      input_divider
);

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        pll_bridge_pkg::tap_state_t st;
        logic        rst_n;
        logic        cap;
        logic        sh;
        logic        upd;
        logic [7:0]  ir_sr;
        logic [7:0]  ir;
        logic        hold;
        logic        mode;
        logic [26:0] sr;
        logic [26:0] lat;
        logic [26:0] act;
        logic        lock;
        logic        tdo;
        logic        oe;
    } bridge_state_t;

    bridge_state_t q;
    bridge_state_t d;
    logic          is_load;
    logic          is_dyn;
    logic          cfg_shift_enable;
    logic          cfg_update_pulse;
    logic          cfg_serial_in;
    logic          cfg_serial_out;

    ////////////////////////////////////////////////////////////////////
    // tap state transitions
    function automatic pll_bridge_pkg::tap_state_t tap_next(
        input pll_bridge_pkg::tap_state_t s,
        input logic                       m
    );
        unique case (s)
            pll_bridge_pkg::st_tlr:
                tap_next = m ? pll_bridge_pkg::st_tlr
                             : pll_bridge_pkg::st_rti;
            pll_bridge_pkg::st_rti,
            pll_bridge_pkg::st_upd_dr,
            pll_bridge_pkg::st_upd_ir:
                tap_next = m ? pll_bridge_pkg::st_sel_dr
                             : pll_bridge_pkg::st_rti;
            pll_bridge_pkg::st_sel_dr:
                tap_next = m ? pll_bridge_pkg::st_sel_ir
                             : pll_bridge_pkg::st_cap_dr;
            pll_bridge_pkg::st_cap_dr,
            pll_bridge_pkg::st_sh_dr,
            pll_bridge_pkg::st_ex2_dr:
                tap_next = m ? pll_bridge_pkg::st_ex1_dr
                             : pll_bridge_pkg::st_sh_dr;
            pll_bridge_pkg::st_ex1_dr:
                tap_next = m ? pll_bridge_pkg::st_upd_dr
                             : pll_bridge_pkg::st_pa_dr;
            pll_bridge_pkg::st_pa_dr:
                tap_next = m ? pll_bridge_pkg::st_ex2_dr
                             : pll_bridge_pkg::st_pa_dr;
            pll_bridge_pkg::st_sel_ir:
                tap_next = m ? pll_bridge_pkg::st_tlr
                             : pll_bridge_pkg::st_cap_ir;
            pll_bridge_pkg::st_cap_ir,
            pll_bridge_pkg::st_sh_ir,
            pll_bridge_pkg::st_ex2_ir:
                tap_next = m ? pll_bridge_pkg::st_ex1_ir
                             : pll_bridge_pkg::st_sh_ir;
            pll_bridge_pkg::st_ex1_ir:
                tap_next = m ? pll_bridge_pkg::st_upd_ir
                             : pll_bridge_pkg::st_pa_ir;
            pll_bridge_pkg::st_pa_ir:
                tap_next = m ? pll_bridge_pkg::st_ex2_ir
                             : pll_bridge_pkg::st_pa_ir;
        endcase
    endfunction : tap_next

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        is_load = (q.ir == pll_bridge_pkg::OP_LOAD_CFG);
        is_dyn  = (q.ir == pll_bridge_pkg::OP_DYNAMIC);
        cfg_shift_enable = q.sh && is_load;
        cfg_update_pulse = q.upd && is_load;
        cfg_serial_in    = tdi;
        cfg_serial_out   = q.sr[0];

        // strobes mirror the state being entered
        d.st    = tap_next(q.st, tms);
        d.rst_n = (d.st != pll_bridge_pkg::st_tlr);
        d.cap   = (d.st == pll_bridge_pkg::st_cap_dr);
        d.sh    = (d.st == pll_bridge_pkg::st_sh_dr);
        d.upd   = (d.st == pll_bridge_pkg::st_upd_dr);

        // instruction register
        if (q.st == pll_bridge_pkg::st_tlr) begin
            d.ir = pll_bridge_pkg::IR_RESET;
        end else if (q.st == pll_bridge_pkg::st_cap_ir) begin
            d.ir_sr = pll_bridge_pkg::IR_CAPTURE;
        end else if (q.st == pll_bridge_pkg::st_sh_ir) begin
            d.ir_sr = {tdi, q.ir_sr[7:1]};
        end else if (q.st == pll_bridge_pkg::st_upd_ir) begin
            d.ir = q.ir_sr;
        end

        // one-bit holding register
        if (q.cap) begin
            d.hold = is_dyn ? q.mode : 1'b0;
        end else if (q.sh) begin
            d.hold = tdi;
        end

        // pll config shift register and its latches
        if (cfg_shift_enable) begin
            d.sr = {cfg_serial_in, q.sr[26:1]};
        end
        if (cfg_update_pulse) begin
            d.lat = q.sr;
        end

        // mode latch
        if (!q.rst_n) begin
            d.mode = 1'b0;
        end else if (q.upd && is_dyn) begin
            d.mode = q.hold;
        end

        // active control bits
        d.act = d.mode ? d.lat : pll_bridge_pkg::STATIC_CFG;

        // lock holds through updates; feedback source 00 resets the pll
        if (d.act[pll_bridge_pkg::FB_SEL_LSB +: 2] == 2'h0) begin
            d.lock = 1'b0;
        end else if (pll_lock_in) begin
            d.lock = 1'b1;
        end

        // test data out for the next shift edge
        if (d.st == pll_bridge_pkg::st_sh_ir) begin
            d.tdo = d.ir_sr[0];
        end else if (d.ir == pll_bridge_pkg::OP_LOAD_CFG) begin
            d.tdo = d.sr[0];
        end else begin
            d.tdo = d.hold;
        end
        d.oe = (d.st == pll_bridge_pkg::st_sh_dr)
            || (d.st == pll_bridge_pkg::st_sh_ir);
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q.st    <= pll_bridge_pkg::st_tlr;
            q.rst_n <= 1'b0;
            q.cap   <= 1'b0;
            q.sh    <= 1'b0;
            q.upd   <= 1'b0;
            q.ir_sr <= pll_bridge_pkg::IR_RESET;
            q.ir    <= pll_bridge_pkg::IR_RESET;
            q.hold  <= 1'b0;
            q.mode  <= 1'b0;
            q.sr    <= 27'h0000000;
            q.lat   <= 27'h0000000;
            q.act   <= pll_bridge_pkg::STATIC_CFG;
            q.lock  <= 1'b0;
            q.tdo   <= 1'b0;
            q.oe    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign tdo                 = q.tdo;
    assign tdo_oe              = q.oe;
    assign current_instruction = q.ir;
    assign tap_reset_n         = q.rst_n;
    assign dr_shift_strobe     = q.sh;
    assign dr_update_strobe    = q.upd;
    assign dr_capture_strobe   = q.cap;
    assign mode                = q.mode;
    assign pll_locked          = q.lock;
    assign fixed_delay_select  = q.act[pll_bridge_pkg::FIX_DLY_BIT];
    assign feedback_delay_tap  =
        q.act[pll_bridge_pkg::FB_DLY_LSB +: pll_bridge_pkg::FB_DLY_W];
    assign feedback_source_select =
        q.act[pll_bridge_pkg::FB_SEL_LSB +: pll_bridge_pkg::FB_SEL_W];
    assign out_b_source_select =
        q.act[pll_bridge_pkg::OB_MUX_LSB +: pll_bridge_pkg::OB_MUX_W];
    assign out_a_source_select =
        q.act[pll_bridge_pkg::OA_MUX_LSB +: pll_bridge_pkg::OA_MUX_W];
    assign out_a_divider       =
        q.act[pll_bridge_pkg::OA_DIV_LSB +: pll_bridge_pkg::OA_DIV_W];
    assign out_b_divider       =
        q.act[pll_bridge_pkg::OB_DIV_LSB +: pll_bridge_pkg::OB_DIV_W];
    assign feedback_divider    =
        q.act[pll_bridge_pkg::FB_DIV_LSB +: pll_bridge_pkg::FB_DIV_W];
    assign input_divider       =
        q.act[pll_bridge_pkg::IN_DIV_LSB +: pll_bridge_pkg::IN_DIV_W];

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_opcode_range;
        (pll_bridge_pkg::OP_LOAD_CFG >= pll_bridge_pkg::OP_USER_MIN)
        && (pll_bridge_pkg::OP_LOAD_CFG <= pll_bridge_pkg::OP_USER_MAX)
        && (pll_bridge_pkg::OP_LOAD_CFG == 8'h20)
        && (pll_bridge_pkg::OP_DYNAMIC == 8'h21);
    endproperty
    a_opcode_range: assert property (p_opcode_range)
        else $error("config opcodes out of range");

    property p_update_fields;
        (cfg_update_pulse && q.mode) |=>
            ({fixed_delay_select, feedback_delay_tap,
              feedback_source_select, out_b_source_select,
              out_a_source_select, out_a_divider, out_b_divider,
              feedback_divider, input_divider} == $past(q.sr));
    endproperty
    a_update_fields: assert property (p_update_fields)
        else $error("fields do not follow updated word");

    property p_static_cfg;
        !mode |-> ({fixed_delay_select, feedback_delay_tap,
                    feedback_source_select, out_b_source_select,
                    out_a_source_select, out_a_divider, out_b_divider,
                    feedback_divider, input_divider}
                   == pll_bridge_pkg::STATIC_CFG);
    endproperty
    a_static_cfg: assert property (p_static_cfg)
        else $error("static word not in use with mode low");

    property p_shift_in;
        (dr_shift_strobe && current_instruction
            == pll_bridge_pkg::OP_LOAD_CFG)
        |=> (q.sr == {$past(tdi), $past(q.sr[26:1])});
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("config register did not shift");

    property p_shift_hold;
        !(dr_shift_strobe && current_instruction
            == pll_bridge_pkg::OP_LOAD_CFG) |=> $stable(q.sr);
    endproperty
    a_shift_hold: assert property (p_shift_hold)
        else $error("config register moved while disabled");

    property p_act_stable;
        (!dr_update_strobe && !$changed(mode)) ##1 !$changed(mode)
        |-> $stable(q.act);
    endproperty
    a_act_stable: assert property (p_act_stable)
        else $error("active config changed without update");

    property p_strobe_seq;
        (dr_capture_strobe && !tms |=> dr_shift_strobe && !dr_capture_strobe)
        and ((dr_shift_strobe && tms) ##1 tms
             |=> dr_update_strobe && !dr_shift_strobe);
    endproperty
    a_strobe_seq: assert property (p_strobe_seq)
        else $error("dr strobes out of step with tap state");

    property p_tap_reset;
        tms [*5] |=> !tap_reset_n && !dr_shift_strobe;
    endproperty
    a_tap_reset: assert property (p_tap_reset)
        else $error("tap reset not reached after five tms highs");

    property p_hold_capture;
        dr_capture_strobe |=> (q.hold == ($past(is_dyn) ?
                                          $past(mode) : 1'b0));
    endproperty
    a_hold_capture: assert property (p_hold_capture)
        else $error("holding bit capture wrong");

    property p_mode_load;
        (dr_update_strobe && is_dyn && tap_reset_n)
        |=> (mode == $past(q.hold));
    endproperty
    a_mode_load: assert property (p_mode_load)
        else $error("mode not loaded on update");

    property p_mode_clear;
        !tap_reset_n |=> !mode;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("mode not cleared by tap reset");

    property p_tdo_mux;
        (q.oe && q.st == pll_bridge_pkg::st_sh_dr) |->
            (tdo == (is_load ? cfg_serial_out : q.hold));
    endproperty
    a_tdo_mux: assert property (p_tdo_mux)
        else $error("tdo source wrong");

    property p_lock_keep;
        pll_locked ##1 (feedback_source_select != 2'h0) |-> pll_locked;
    endproperty
    a_lock_keep: assert property (p_lock_keep)
        else $error("lock dropped without pll reset");

    c_cfg_update: cover property (cfg_update_pulse ##1 mode);
    c_mode_on: cover property (!mode ##1 mode);
    c_lock_drop: cover property (pll_locked ##1 !pll_locked);
    c_shift_run: cover property (cfg_shift_enable [*8]);

endmodule : pll_cfg_bridge

//--- verification/jtag_tester.sv
// Purpose: behavioural jtag tester that drives the tap pins
// Assumes: pins change at the falling clock edge only
// Notes:   tdi toggles whenever no data bit is being shifted
module jtag_tester (
    // clock
    input  wire logic clk,
    // tap pins
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tms = 1'b1;
        tdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // one tap cycle; idle keeps tdi moving so stale data is never seen
    task automatic step(input logic m, input logic d);
        @(negedge clk);
        tms = m;
        tdi = d;
    endtask : step

    task automatic idle(input logic m);
        step(m, ~tdi);
    endtask : idle

    task automatic reset_tap();
        repeat (5) idle(1'b1);
        idle(1'b0);
        idle(1'b0);
    endtask : reset_tap

    ////////////////////////////////////////////////////////////////////
    // opcode is one of the user codes, sent lsb first
    task automatic scan_ir(input logic [7:0] op);
        idle(1'b1);
        idle(1'b1);
        idle(1'b0);
        idle(1'b0);
        for (int i = 0; i < 8; i++) begin
            step(i == 7, op[i]);
        end
        idle(1'b1);
        idle(1'b0);
        idle(1'b0);
    endtask : scan_ir

    // ends after the last shift bit, before update
    task automatic scan_dr(input int n, input logic [26:0] din,
                           output logic [26:0] dout);
        dout = '0;
        idle(1'b1);
        idle(1'b0);
        idle(1'b0);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            dout[i] = tdo;
            tms     = (i == n - 1);
            tdi     = din[i];
        end
    endtask : scan_dr

    // update only once shifting has ended
    task automatic update_dr();
        idle(1'b1);
        idle(1'b0);
        idle(1'b0);
    endtask : update_dr

endmodule : jtag_tester

//--- verification/tb_top.sv
// Purpose: self-checking bench for the tap to pll config bridge
// Assumes: tester drives tms and tdi at falling edges
// Notes:   expected words come from the bench constants and the package static word
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [26:0] WORD_A = 27'h5A5C3B1;
    localparam logic [26:0] WORD_B = 27'h3E1D2C7;
    localparam logic [26:0] WORD_R = WORD_B & ~27'h0300000;
    localparam logic [26:0] WORD_P = 27'h1234567;

    logic        clk, resetn, tms, tdi, tdo, tdo_oe, tap_reset_n;
    logic        dr_shift_strobe, dr_update_strobe, dr_capture_strobe;
    logic        pll_lock_in, mode, pll_locked, fixed_delay_select;
    logic [7:0]  current_instruction;
    logic [3:0]  feedback_delay_tap;
    logic [1:0]  feedback_source_select, out_a_source_select;
    logic [2:0]  out_b_source_select;
    logic [1:0]  out_a_divider, out_b_divider;
    logic [5:0]  feedback_divider;
    logic [4:0]  input_divider;
    logic [26:0] seen, active, ir_ext;
    int          err_total = 0;
    int          comparisons = 0;
    int          n_cap = 0;
    int          n_sh = 0;
    int          n_upd = 0;
    int          n_oe = 0;
    int          c0, s0, u0, o0;

    assign active = {fixed_delay_select, feedback_delay_tap,
                     feedback_source_select, out_b_source_select,
                     out_a_source_select, out_a_divider, out_b_divider,
                     feedback_divider, input_divider};
    assign ir_ext = {19'h0, current_instruction};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    pll_cfg_bridge dut (
        .clk(clk), .resetn(resetn), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .current_instruction(current_instruction),
        .tap_reset_n(tap_reset_n), .dr_shift_strobe(dr_shift_strobe),
        .dr_update_strobe(dr_update_strobe),
        .dr_capture_strobe(dr_capture_strobe),
        .pll_lock_in(pll_lock_in), .mode(mode), .pll_locked(pll_locked),
        .fixed_delay_select(fixed_delay_select),
        .feedback_delay_tap(feedback_delay_tap),
        .feedback_source_select(feedback_source_select),
        .out_b_source_select(out_b_source_select),
        .out_a_source_select(out_a_source_select),
        .out_a_divider(out_a_divider), .out_b_divider(out_b_divider),
        .feedback_divider(feedback_divider), .input_divider(input_divider)
    );

    jtag_tester tester (.clk(clk), .tms(tms), .tdi(tdi), .tdo(tdo));

    always @(negedge clk) begin
        n_cap <= n_cap + int'(dr_capture_strobe);
        n_sh  <= n_sh + int'(dr_shift_strobe);
        n_upd <= n_upd + int'(dr_update_strobe);
        n_oe  <= n_oe + int'(tdo_oe);
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string what, input logic [26:0] exp,
                            input logic [26:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////
    initial begin
        #40000;
        err_total++;
        $display("mismatch watchdog expected done seen timeout");
        summarize();
    end

    initial begin
        resetn      = 1'b0;
        pll_lock_in = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        chk_bit("tap_reset_n", 1'b0, tap_reset_n);
        chk_word("instruction", 27'h00000FF, ir_ext);
        chk_word("active word", pll_bridge_pkg::STATIC_CFG, active);
        tester.reset_tap();
        chk_bit("tap_reset_n", 1'b1, tap_reset_n);
        $display("test power_up done");

        tester.scan_ir(pll_bridge_pkg::OP_LOAD_CFG);
        chk_word("instruction", 27'h0000020, ir_ext);
        c0 = n_cap;
        s0 = n_sh;
        u0 = n_upd;
        o0 = n_oe;
        tester.scan_dr(27, WORD_A, seen);
        tester.update_dr();
        chk_word("shift cycles", 27'h000001B, 27'(n_sh - s0));
        chk_word("enable cycles", 27'h000001B, 27'(n_oe - o0));
        chk_word("capture cycles", 27'h0000001, 27'(n_cap - c0));
        chk_word("update cycles", 27'h0000001, 27'(n_upd - u0));
        chk_word("active word", pll_bridge_pkg::STATIC_CFG, active);
        tester.scan_ir(pll_bridge_pkg::OP_DYNAMIC);
        tester.scan_dr(1, 27'h0000001, seen);
        tester.update_dr();
        chk_word("held mode", 27'h0000000, seen);
        chk_bit("mode", 1'b1, mode);
        chk_word("active word", WORD_A, active);
        tester.scan_dr(1, 27'h0000001, seen);
        tester.update_dr();
        chk_word("held mode", 27'h0000001, seen);
        $display("test load_and_mode done");

        pll_lock_in = 1'b1;
        tester.idle(1'b0);
        tester.idle(1'b0);
        chk_bit("pll_locked", 1'b1, pll_locked);
        pll_lock_in = 1'b0;
        tester.scan_ir(pll_bridge_pkg::OP_LOAD_CFG);
        tester.scan_dr(27, WORD_B, seen);
        chk_word("active word", WORD_A, active);
        chk_word("shifted out", WORD_A, seen);
        tester.update_dr();
        chk_word("active word", WORD_B, active);
        chk_bit("pll_locked", 1'b1, pll_locked);
        $display("test shadow_update done");

        tester.scan_ir(pll_bridge_pkg::OP_USER_MIN);
        tester.scan_dr(27, WORD_P, seen);
        tester.update_dr();
        chk_word("bypass out", {WORD_P[25:0], 1'b0}, seen);
        chk_word("active word", WORD_B, active);
        tester.scan_ir(pll_bridge_pkg::OP_LOAD_CFG);
        tester.scan_dr(27, WORD_R, seen);
        tester.update_dr();
        chk_word("held config", WORD_B, seen);
        tester.idle(1'b0);
        chk_bit("pll_locked", 1'b0, pll_locked);
        pll_lock_in = 1'b1;
        tester.scan_dr(27, WORD_B, seen);
        tester.update_dr();
        tester.idle(1'b0);
        tester.idle(1'b0);
        chk_word("shifted out", WORD_R, seen);
        chk_bit("pll_locked", 1'b1, pll_locked);
        $display("test bypass_and_relock done");

        tester.reset_tap();
        chk_bit("mode", 1'b0, mode);
        chk_word("instruction", 27'h00000FF, ir_ext);
        chk_word("active word", pll_bridge_pkg::STATIC_CFG, active);
        $display("test tap_reset done");
        summarize();
    end

endmodule : tb_top
